// file: dv/rmg_gateway_tb.sv
// Self-checking bench of the remote I/O and monitor gateway
`timescale 1ns/1ps
module rmg_gateway_tb;
  import rmg_pkg::*;
  logic i_clk = 1'b0, i_rst_n = 1'b0, io_wr = 1'b0, cfg_wr = 1'b0, cfg_en = 1'b0;
  logic pwr = 1'b0, proto = 1'b0, go = 1'b0, request_trigger, busy, refd;
  logic [15:0] ofs = 16'h0000, wdata = 16'h0000, cmd = 16'h0000;
  logic [7:0]  axis = 8'h00, hold = 8'h08, st;
  logic [3:0]  cfg_a = 4'h0, rate = 4'h0;
  logic [31:0] mon, rdata, per, keep;
  logic [2:0]  ops, dss;
  logic [7:0]  raxis;
  logic [15:0] rcmd, aen;
  logic        s, h, p, f, ss, jp, jm, fw, rv, r625;
  int mismatches = 0, n_tests = 0;
  // Ordinary decode cases: written word beside expected decoded outputs
  logic [15:0] row_in [9] = '{16'h0009, 16'h0070, 16'h0087, 16'h0700, 16'h1800,
                              16'h2000, 16'h4000, 16'h8000, 16'h0000};
  logic [14:0] row_ex [9] = '{15'h1800, 15'h0700, 15'h7000, 15'h00e0, 15'h0018,
                              15'h0004, 15'h0002, 15'h0001, 15'h0000};
  always #50 i_clk = ~i_clk;
  rmg_host_model u_rmg_host_model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go), .i_hold(hold),
    .o_request_trigger(request_trigger), .o_mon_value(mon), .o_busy(busy));
  rmg_gateway u_rmg_gateway (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_io_wr(io_wr), .i_io_ofs(ofs),
    .i_io_wdata(wdata), .i_mon_axis(axis), .i_mon_command(cmd), .i_request_trigger(request_trigger),
    .i_mon_value(mon), .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_a), .i_cfg_enable(cfg_en),
    .i_power_on(pwr), .i_protocol_sw(proto), .i_rate_select_switch(rate), .o_op_select(ops),
    .o_start(s), .o_home(h), .o_stop(p), .o_free(f), .o_direct_start_select(dss),
    .o_sequential_start(ss), .o_jog_plus(jp), .o_jog_minus(jm), .o_forward_run(fw),
    .o_reverse_run(rv), .o_resp_axis(raxis), .o_resp_command(rcmd), .o_resp_data(rdata),
    .o_resp_status(st), .o_addr_enable(aen), .o_rate_625k(r625), .o_bit_period_clks(per),
    .o_cfg_refused(refd));
  // One comparison, counted; mismatch reported at once
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Fieldbus write; refusal flag gathered over the two cycles after the taking edge
  task automatic io_write(input logic [15:0] o, input logic [15:0] d, output logic rf);
    @(posedge i_clk);
    io_wr <= 1'b1;
    ofs   <= o;
    wdata <= d;
    @(posedge i_clk);
    io_wr <= 1'b0;
    @(negedge i_clk);
    rf = refd;
    @(negedge i_clk);
    rf = rf | refd;
    @(negedge i_clk);
  endtask
  // Monitor request through the host model; masked status compared
  task automatic monitor(input logic [7:0] a, input logic [15:0] c, input logic [7:0] msk,
                         input logic [7:0] exp);
    int i;
    @(posedge i_clk);
    axis <= a;
    cmd  <= c;
    go   <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    for (i = 0; i < 8 && st === 8'h00; i++)
      @(negedge i_clk);
    check(st & msk, exp);
    for (i = 0; i < 3 && exp === 8'h01; i++)
    begin
      check({raxis, rcmd}, {a, c});
      check(rdata, mon - 32'h1);
      @(negedge i_clk);
    end
    for (i = 0; i < 20 && busy === 1'b1; i++)
      @(negedge i_clk);
    check(busy, 1'b0);
    check(st, 8'h00);
    keep = rdata;
    repeat (3) @(negedge i_clk);
    check(rdata, keep);
  endtask
  initial
  begin
    #(100 * 3000);
    mismatches++;
    summarize();
  end
  initial
  begin
    logic rf;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    check(aen, 16'h0000);
    // Decode table, one write per row, each checked before the next
    for (int k = 0; k < 9; k++)
    begin
      io_write(RMG_OFS_REMOTE_IO, row_in[k], rf);
      check(rf, 1'b0);
      check({ops, s, h, p, f, dss, ss, jp, jm, fw, rv}, row_ex[k]);
    end
    // Writes elsewhere refused, word kept
    io_write(16'h0009, 16'h0000, rf);
    check(rf, 1'b1);
    io_write(RMG_OFS_MON_RESP, 16'hffff, rf);
    check(rf, 1'b1);
    check({ops, s, h, p, f, dss, ss, jp, jm, fw, rv}, 15'h0000);
    // Rate switch
    @(posedge i_clk) rate <= 4'h7;
    repeat (4) @(negedge i_clk);
    check({r625, per}, {1'b1, 32'h10});
    @(posedge i_clk) rate <= 4'h6;
    repeat (4) @(negedge i_clk);
    check({r625, per}, 33'h0);
    // Enable pending only, so the request still fails on the axis
    @(posedge i_clk);
    cfg_wr <= 1'b1;
    cfg_a  <= 4'h3;
    cfg_en <= 1'b1;
    @(posedge i_clk) cfg_wr <= 1'b0;
    monitor(8'h03, 16'h2067, 8'hff, 8'h04);
    check(aen, 16'h0000);
    @(posedge i_clk) pwr <= 1'b1;
    repeat (4) @(negedge i_clk);
    check(aen, 16'h0008);
    monitor(8'h03, 16'h2067, 8'hff, 8'h01);
    monitor(8'h03, 16'h3000, 8'hff, 8'h08);
    monitor(8'h10, 16'h2000, 8'hff, 8'h04);
    monitor(8'h03, 16'h20ff, 8'hff, 8'h01);
    @(posedge i_clk) proto <= 1'b1;
    repeat (3) @(posedge i_clk);
    monitor(8'h03, 16'h2067, 8'h03, 8'h00);
    // Second reset in mid-run clears active enables
    @(posedge i_clk) i_rst_n <= 1'b0;
    @(negedge i_clk);
    check({aen, st}, 24'h0);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    proto   <= 1'b0;
    // First two edges after release: outputs still at reset values
    @(negedge i_clk);
    check({aen, st, refd}, 25'h0);
    @(negedge i_clk);
    check({aen, st, refd}, 25'h0);
    // Enables cleared again, so axis 3 is refused on the axis
    monitor(8'h03, 16'h2067, 8'hff, 8'h04);
    summarize();
  end
endmodule // rmg_gateway_tb

// file: dv/rmg_host_model.sv
// Host-side model: monitor trigger handshake and a changing monitored value
`timescale 1ns/1ps
module rmg_host_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Bench control
  input  wire logic        i_go,
  input  wire logic [7:0]  i_hold,
  // Toward the gateway, and busy back to the bench
  output logic             o_request_trigger,
  output logic [31:0]      o_mon_value,
  output logic             o_busy
);
  logic [7:0] cnt_r; // Cycles left in phase
  logic       gap_r; // Low guard after a request
  assign o_busy = o_request_trigger | gap_r;
  // Trigger held, then cleared and kept low long enough for a new request
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_request_trigger <= 1'b0;
      gap_r             <= 1'b0;
      cnt_r             <= 8'h00;
    end
    else if (i_go && !o_busy)
    begin
      o_request_trigger <= 1'b1;
      cnt_r             <= i_hold;
    end
    else if (o_busy)
    begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01)
      begin
        o_request_trigger <= 1'b0;
        gap_r             <= o_request_trigger;
        cnt_r             <= o_request_trigger ? 8'h04 : 8'h00;
      end
    end
  end
  // Signed quantity that moves every cycle, starting negative
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_mon_value <= 32'hfffffff0;
    else
      o_mon_value <= o_mon_value + 32'h1;
  end
endmodule // rmg_host_model

// file: rtl/rmg_gateway.sv
// Remote I/O and remote monitor gateway of the motor driver link
`timescale 1ns/1ps
module rmg_gateway
  import rmg_pkg::*;
#(
  parameter int RMG_CLK_HZ = 10000000  // System clock rate
)(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Remote I/O write port (fieldbus side)
  input  wire logic        i_io_wr,
  input  wire logic [15:0] i_io_ofs,
  input  wire logic [15:0] i_io_wdata,
  // Remote monitor command
  input  wire logic [7:0]  i_mon_axis,
  input  wire logic [15:0] i_mon_command,
  input  wire logic        i_request_trigger,
  // Monitored quantity from the drive
  input  wire logic [31:0] i_mon_value,
  // Configuration tool path and power sense for address enables
  input  wire logic        i_cfg_wr,
  input  wire logic [3:0]  i_cfg_addr,
  input  wire logic        i_cfg_enable,
  input  wire logic        i_power_on,
  // Driver switches
  input  wire logic        i_protocol_sw,
  input  wire logic [3:0]  i_rate_select_switch,
  // Decoded remote inputs
  output logic [2:0]       o_op_select,
  output logic             o_start,
  output logic             o_home,
  output logic             o_stop,
  output logic             o_free,
  output logic [2:0]       o_direct_start_select,
  output logic             o_sequential_start,
  output logic             o_jog_plus,
  output logic             o_jog_minus,
  output logic             o_forward_run,
  output logic             o_reverse_run,
  // Monitor response
  output logic [7:0]       o_resp_axis,
  output logic [15:0]      o_resp_command,
  output logic [31:0]      o_resp_data,
  output logic [7:0]       o_resp_status,
  // Link and configuration state
  output logic [15:0]      o_addr_enable,
  output logic             o_rate_625k,
  output logic [31:0]      o_bit_period_clks,
  output logic             o_cfg_refused
);
  import rmg_pkg::*;

  // Synchronised pins
  logic        request_trigger_s1_r, request_trigger_s2_r;      // Trigger synchroniser
  logic        pwr_s1_r,  pwr_s2_r;       // Power sense synchroniser
  logic        proto_s1_r, proto_s2_r;    // Protocol switch synchroniser
  logic [3:0]  rate_s1_r, rate_s2_r;      // Rate switch synchroniser
  logic        pwr_d_r;                   // Power sense delayed for edge
  // Address enable storage
  logic [15:0] enable_pend_r;             // Written by tool, not yet active
  logic [15:0] enable_act_r;              // Active set since last power up
  // Remote input word
  logic [15:0] io_word_r;
  // Monitor path
  rmg_state_e  state_r, state_nxt;
  logic        req_valid;                 // Axis and code both good
  logic        axis_ok, code_ok;

  // Two-flop synchronisers on the trigger, power sense, protocol switch and rate switch inputs
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      request_trigger_s1_r  <= 1'b0;
      request_trigger_s2_r  <= 1'b0;
      pwr_s1_r   <= 1'b0;
      pwr_s2_r   <= 1'b0;
      proto_s1_r <= 1'b0;
      proto_s2_r <= 1'b0;
      rate_s1_r  <= 4'h0;
      rate_s2_r  <= 4'h0;
      pwr_d_r    <= 1'b0;
    end
    else
    begin
      request_trigger_s1_r  <= i_request_trigger;
      request_trigger_s2_r  <= request_trigger_s1_r;
      pwr_s1_r   <= i_power_on;
      pwr_s2_r   <= pwr_s1_r;
      proto_s1_r <= i_protocol_sw;
      proto_s2_r <= proto_s1_r;
      rate_s1_r  <= i_rate_select_switch;
      rate_s2_r  <= rate_s1_r;
      pwr_d_r    <= pwr_s2_r;
    end
  end

  // Remote I/O word; only the remote I/O offset is writable from the fieldbus
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      io_word_r <= 16'h0000;
    else if (i_io_wr && i_io_ofs == RMG_OFS_REMOTE_IO)
      io_word_r <= i_io_wdata;
  end

  // Fieldbus writes to any other offset are refused (one-cycle pulse)
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_cfg_refused <= 1'b0;
    else
      o_cfg_refused <= i_io_wr && (i_io_ofs != RMG_OFS_REMOTE_IO);
  end

  // Decode of the remote input word into control lines
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_op_select           <= 3'h0;
      o_start               <= 1'b0;
      o_home                <= 1'b0;
      o_stop                <= 1'b0;
      o_free                <= 1'b0;
      o_direct_start_select <= 3'h0;
      o_sequential_start    <= 1'b0;
      o_jog_plus            <= 1'b0;
      o_jog_minus           <= 1'b0;
      o_forward_run         <= 1'b0;
      o_reverse_run         <= 1'b0;
    end
    else
    begin
      // Bit 7 is unused and ignored
      o_op_select           <= io_word_r[RMG_BIT_OPSEL_LO +: 3];
      o_start               <= io_word_r[RMG_BIT_START];
      o_home                <= io_word_r[RMG_BIT_HOME];
      o_stop                <= io_word_r[RMG_BIT_STOP];
      o_free                <= io_word_r[RMG_BIT_FREE];
      o_direct_start_select <= io_word_r[RMG_BIT_DSEL_LO +: 3];
      o_sequential_start    <= io_word_r[RMG_BIT_SEQUENTIAL_START];
      o_jog_plus            <= io_word_r[RMG_BIT_JOG_PLUS];
      o_jog_minus           <= io_word_r[RMG_BIT_JOG_MINUS];
      o_forward_run         <= io_word_r[RMG_BIT_FWD];
      o_reverse_run         <= io_word_r[RMG_BIT_RVS];
    end
  end

  // Tool-path writes go to the pending set only
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      enable_pend_r <= 16'h0000;
    else if (i_cfg_wr)
      enable_pend_r[i_cfg_addr] <= i_cfg_enable;
  end

  // Pending set becomes active only on a power-up edge
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      enable_act_r <= 16'h0000;
    else if (pwr_s2_r && !pwr_d_r)
      enable_act_r <= enable_pend_r;
  end

  assign o_addr_enable = enable_act_r;

  // Request validity: axis in range and enabled, driver set to converter mode
  always_comb
  begin
    axis_ok = (i_mon_axis < 8'(RMG_NUM_ADDR)) && enable_act_r[i_mon_axis[3:0]] && !proto_s2_r;
    code_ok = (i_mon_command >= RMG_MON_CODE_LO) && (i_mon_command <= RMG_MON_CODE_HI);
    req_valid = axis_ok && code_ok;
  end

  // Monitor state: idle, running, or refused request
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      RMG_IDLE: if (request_trigger_s2_r) state_nxt = req_valid ? RMG_RUN : RMG_ERR;
      RMG_RUN:  if (!request_trigger_s2_r) state_nxt = RMG_IDLE;
      RMG_ERR:  if (!request_trigger_s2_r) state_nxt = RMG_IDLE;
      default:  state_nxt = RMG_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_r <= RMG_IDLE;
    else
      state_r <= state_nxt;
  end

  // Response echo and refresh; data frozen once trigger is gone
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_resp_axis    <= 8'h00;
      o_resp_command <= 16'h0000;
      o_resp_data    <= 32'h0000_0000;
    end
    else if (state_nxt == RMG_RUN)
    begin
      o_resp_axis    <= i_mon_axis;
      o_resp_command <= i_mon_command;
      o_resp_data    <= i_mon_value;
    end
  end

  // Status byte, upper bits zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_resp_status <= 8'h00;
    else
    begin
      o_resp_status                    <= 8'h00;
      o_resp_status[RMG_ST_REQUEST_TRIGGER_ACK]   <= (state_nxt == RMG_RUN);
      o_resp_status[RMG_ST_CMD_STATUS] <= 1'b0;
      // Errors latched only on a refused request
      o_resp_status[RMG_ST_AXIS_ERR]   <= (state_nxt == RMG_ERR) && !axis_ok;
      o_resp_status[RMG_ST_CMD_ERR]    <= (state_nxt == RMG_ERR) && !code_ok;
      if (state_r == RMG_ERR && state_nxt == RMG_ERR)
      begin
        // Hold error flags for the life of the refused request
        o_resp_status[RMG_ST_AXIS_ERR] <= o_resp_status[RMG_ST_AXIS_ERR];
        o_resp_status[RMG_ST_CMD_ERR]  <= o_resp_status[RMG_ST_CMD_ERR];
      end
    end
  end

  // Link rate from the rate switch; unknown codes leave the period at zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rate_625k       <= 1'b0;
      o_bit_period_clks <= 32'h0000_0000;
    end
    else
    begin
      o_rate_625k       <= (rate_s2_r == RMG_RATE_CODE_625K);
      o_bit_period_clks <= (rate_s2_r == RMG_RATE_CODE_625K) ? 32'(RMG_CLK_HZ / RMG_RATE_625K_BPS) : 32'h0;
    end
  end

  // Checks
  a_ack_no_status: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_resp_status[RMG_ST_REQUEST_TRIGGER_ACK] |-> !o_resp_status[RMG_ST_CMD_STATUS])
    else $error("ack with command status set");
  a_ack_follows_request_trigger: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == RMG_RUN && request_trigger_s2_r) |=> o_resp_status[RMG_ST_REQUEST_TRIGGER_ACK])
    else $error("ack lost while trigger held");
  a_data_refresh: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_nxt == RMG_RUN) |=> (o_resp_data == $past(i_mon_value)))
    else $error("monitor data not refreshed");
  a_data_frozen: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == RMG_IDLE && !request_trigger_s2_r) |=> $stable(o_resp_data))
    else $error("monitor data moved after trigger cleared");
  a_echo_axis: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_nxt == RMG_RUN) |=> (o_resp_axis == $past(i_mon_axis)))
    else $error("axis echo wrong");
  a_status_upper: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_resp_status[7:4] == 4'h0)
    else $error("status upper bits set");
  a_enable_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(pwr_s2_r && !pwr_d_r) |=> $stable(enable_act_r))
    else $error("enable changed without power cycle");
  a_error_no_ack: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (state_r == RMG_ERR) |-> !o_resp_status[RMG_ST_REQUEST_TRIGGER_ACK])
    else $error("ack on refused request");
  a_rate_code: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rate_s2_r == RMG_RATE_CODE_625K) |=> o_rate_625k)
    else $error("rate code 7 not decoded");
  a_io_refuse: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_io_wr && i_io_ofs != RMG_OFS_REMOTE_IO) |=> o_cfg_refused ##0 $stable(io_word_r))
    else $error("foreign write not refused");

  // Refused request seen: idle, synced trigger, bad axis or code
  sequence s_refused_req;
    state_r == RMG_IDLE && request_trigger_s2_r && !req_valid;
  endsequence
  // Error flag raised and acknowledge withheld
  sequence s_error_flagged;
    (o_resp_status[RMG_ST_AXIS_ERR] || o_resp_status[RMG_ST_CMD_ERR]) && !o_resp_status[RMG_ST_REQUEST_TRIGGER_ACK];
  endsequence
  a_refused_flags: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_refused_req |=> s_error_flagged)
    else $error("refused request without error flag");

endmodule // rmg_gateway

// file: rtl/rmg_pkg.sv
// Package: register offsets, bit positions, codes and limits of the remote I/O gateway
package rmg_pkg;
  // Register offsets (index values of the object map)
  localparam logic [15:0] RMG_OFS_REMOTE_IO   = 16'h2600; // Remote input word
  localparam logic [15:0] RMG_OFS_MON_CMD     = 16'h2a00; // Monitor command
  localparam logic [15:0] RMG_OFS_MON_RESP    = 16'h2b00; // Monitor response
  // Lower remote input byte
  localparam int RMG_BIT_OPSEL_LO   = 0;  // Operation data select, 3 bits
  localparam int RMG_BIT_START      = 3;
  localparam int RMG_BIT_HOME       = 4;
  localparam int RMG_BIT_STOP       = 5;
  localparam int RMG_BIT_FREE       = 6;  // Excitation release
  // Upper remote input byte
  localparam int RMG_BIT_DSEL_LO    = 8;  // Direct start select, 3 bits
  localparam int RMG_BIT_SEQUENTIAL_START     = 11;
  localparam int RMG_BIT_JOG_PLUS   = 12;
  localparam int RMG_BIT_JOG_MINUS  = 13;
  localparam int RMG_BIT_FWD        = 14;
  localparam int RMG_BIT_RVS        = 15;
  // Response status byte
  localparam int RMG_ST_REQUEST_TRIGGER_ACK    = 0;
  localparam int RMG_ST_CMD_STATUS  = 1;
  localparam int RMG_ST_AXIS_ERR    = 2;
  localparam int RMG_ST_CMD_ERR     = 3;
  // Address space of downstream drivers
  localparam int RMG_NUM_ADDR       = 16;
  // Rate selector code for the 625,000 bps link
  localparam logic [3:0] RMG_RATE_CODE_625K = 4'h7;
  localparam int         RMG_RATE_625K_BPS  = 625000;
  // Monitor command code window (valid codes)
  localparam logic [15:0] RMG_MON_CODE_LO = 16'h2000;
  localparam logic [15:0] RMG_MON_CODE_HI = 16'h20ff;
  // Monitor state machine
  typedef enum logic [2:0] {
    RMG_IDLE = 3'b001,
    RMG_RUN  = 3'b010,
    RMG_ERR  = 3'b100
  } rmg_state_e;
endpackage
